//--- tb_tcp_timer_pair.sv
/* Self-checking testbench for the timer/counter pair.
   Assumes the pin model and the checker bound to the design. */
`timescale 1ns/1ps
`include "tcp_consts.svh"

module tb_tcp_timer_pair;
  localparam logic [7:0] CTL = `TCP_ADDR_CTL;
  localparam logic [7:0] MOD = `TCP_ADDR_MODE;
  localparam logic [7:0] L0 = `TCP_ADDR_T0_LO;
  localparam logic [7:0] L1 = `TCP_ADDR_T1_LO;
  localparam logic [7:0] H0 = `TCP_ADDR_T0_HI;
  localparam logic [7:0] H1 = `TCP_ADDR_T1_HI;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  // Order in both vectors: t0, t1, xint0, xint1.
  logic [3:0] ack = 4'h0;
  logic [3:0] flg;
  logic count_pin_0, count_pin_1, ext_irq0_pin, ext_irq1_pin;
  int error_cnt = 0;
  int checks_done = 0;

  always #5 sys_clk = ~sys_clk;

  tcp_timer_pair i_tcp_timer_pair (.sys_clk, .reset_n, .sfr_addr, .sfr_wr,
    .sfr_wdata, .sfr_rd, .sfr_rdata, .t0_irq_ack(ack[0]),
    .t1_irq_ack(ack[1]), .xint0_irq_ack(ack[2]), .xint1_irq_ack(ack[3]),
    .count_pin_0, .count_pin_1, .ext_irq0_pin, .ext_irq1_pin,
    .t0_overflow_flag(flg[0]), .t1_overflow_flag(flg[1]),
    .xint0_edge_flag(flg[2]), .xint1_edge_flag(flg[3]));
  tcp_pin_model i_tcp_pin_model (.sys_clk, .count_pin_0, .count_pin_1,
    .ext_irq0_pin, .ext_irq1_pin);

  /********************/
  /* Bus and checks   */
  /********************/
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= ad;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= ad;
    sfr_rd <= 1'b1;
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask
  task automatic chk(input string what, input logic [7:0] seen,
                     input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_rd(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] d;
    rd(ad, d);
    chk($sformatf("register %h", ad), d, exp);
  endtask
  // Read spacing is exactly two machine cycles, so phase does not matter.
  task automatic rate(input logic [7:0] ad, input logic [7:0] n);
    logic [7:0] a, b;
    rd(ad, a);
    cyc(22);
    rd(ad, b);
    chk($sformatf("count step %h", ad), b, a + n);
  endtask
  task automatic wait_flag(input int s);
    for (int n = 0; n < 40 && flg[s] !== 1'b1; n++) @(posedge sys_clk);
    #1 chk($sformatf("flag %0d set", s), {7'h00, flg[s]}, 8'h01);
  endtask
  task automatic pulse_ack(input int s);
    @(posedge sys_clk);
    ack[s] <= 1'b1;
    @(posedge sys_clk);
    ack[s] <= 1'b0;
    cyc(1);
    #1 chk($sformatf("flag %0d clear", s), {7'h00, flg[s]}, 8'h00);
  endtask
  task automatic complete_run;
    $display("Checks made %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    cyc(20000);
    error_cnt++;
    complete_run;
  end

  initial begin
    cyc(10);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) chk_rd(8'(CTL + i), 8'h00);
    wr(8'h90, 8'hFF);
    chk_rd(8'h90, 8'h00);
    wr(MOD, 8'h5A);
    chk_rd(MOD, 8'h5A);
    wr(CTL, 8'hA0);
    chk_rd(CTL, 8'hA0);
    pulse_ack(0);
    pulse_ack(1);
    $display("Test registers done");
    wr(MOD, 8'h01);
    wr(H0, 8'h00);
    wr(L0, 8'h00);
    wr(CTL, 8'h10);
    rate(L0, 8'h02);
    wr(H0, 8'hFF);
    wr(L0, 8'hFE);
    wait_flag(0);
    chk_rd(H0, 8'h00);
    chk_rd(L0, 8'h00);
    pulse_ack(0);
    wr(CTL, 8'h00);
    rate(L0, 8'h00);
    $display("Test timer done");
    i_tcp_pin_model.set_irq(0, 1'b0);
    wr(MOD, 8'h09);
    wr(L0, 8'h55);
    wr(CTL, 8'h10);
    cyc(36);
    chk_rd(L0, 8'h55);
    i_tcp_pin_model.set_irq(0, 1'b1);
    cyc(10);
    rate(L0, 8'h02);
    $display("Test gate done");
    wr(CTL, 8'h00);
    wr(MOD, 8'h00);
    wr(H1, 8'hFF);
    wr(L1, 8'hFF);
    wr(CTL, 8'h40);
    wait_flag(1);
    chk_rd(L1, 8'hE0);
    chk_rd(H1, 8'h00);
    pulse_ack(1);
    $display("Test prescaler done");
    wr(CTL, 8'h00);
    wr(MOD, 8'h02);
    wr(H0, 8'hA0);
    wr(L0, 8'hFE);
    wr(CTL, 8'h10);
    wait_flag(0);
    chk_rd(L0, 8'hA0);
    chk_rd(H0, 8'hA0);
    pulse_ack(0);
    $display("Test reload done");
    wr(CTL, 8'h00);
    wr(MOD, 8'h33);
    wr(L1, 8'h12);
    wr(L0, 8'h34);
    wr(H0, 8'hFF);
    wr(CTL, 8'h40);
    wait_flag(1);
    chk("t0 flag", {7'h00, flg[0]}, 8'h00);
    chk_rd(H0, 8'h00);
    chk_rd(L0, 8'h34);
    chk_rd(L1, 8'h12);
    pulse_ack(1);
    $display("Test split done");
    wr(CTL, 8'h00);
    wr(MOD, 8'h55);
    for (int i = 0; i < 4; i++) wr(8'(L0 + i), 8'h00);
    wr(CTL, 8'h50);
    cyc(36);
    chk_rd(L0, 8'h00);
    i_tcp_pin_model.pulses(5);
    cyc(30);
    chk_rd(L0, 8'h05);
    chk_rd(L1, 8'h05);
    $display("Test counter done");
    i_tcp_pin_model.set_irq(1, 1'b0);
    cyc(10);
    chk("level flag", {7'h00, flg[3]}, 8'h01);
    i_tcp_pin_model.set_irq(1, 1'b1);
    cyc(10);
    chk("level flag", {7'h00, flg[3]}, 8'h00);
    wr(CTL, 8'h05);
    i_tcp_pin_model.set_irq(0, 1'b0);
    cyc(10);
    i_tcp_pin_model.set_irq(0, 1'b1);
    cyc(10);
    chk("edge flag", {7'h00, flg[2]}, 8'h01);
    pulse_ack(2);
    i_tcp_pin_model.set_irq(1, 1'b0);
    cyc(10);
    i_tcp_pin_model.set_irq(1, 1'b1);
    cyc(10);
    chk("edge flag 1", {7'h00, flg[3]}, 8'h01);
    pulse_ack(3);
    $display("Test interrupts done");
    complete_run;
  end
endmodule // tb_tcp_timer_pair

//--- tcp_consts.svh
/*
 * Constants of the timer/counter pair: register addresses in the special
 * function register space, control and mode bit positions, machine cycle
 * phases and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH

// Register addresses in the special function register space.
`define TCP_ADDR_CTL 8'h88
`define TCP_ADDR_MODE 8'h89
`define TCP_ADDR_T0_LO 8'h8A
`define TCP_ADDR_T1_LO 8'h8B
`define TCP_ADDR_T0_HI 8'h8C
`define TCP_ADDR_T1_HI 8'h8D
`define TCP_UNMAPPED_READ 8'h00

// Control register bit positions.
`define TCP_BIT_TF1 7
`define TCP_BIT_TR1 6
`define TCP_BIT_TF0 5
`define TCP_BIT_TR0 4
`define TCP_BIT_IE1 3
`define TCP_BIT_IT1 2
`define TCP_BIT_IE0 1
`define TCP_BIT_IT0 0

// Mode register fields; timer 1 uses the upper nibble.
`define TCP_MODE_GATE 3
`define TCP_MODE_CNT 2
`define TCP_MODE_SEL_HI 1
`define TCP_MODE_SEL_LO 0
`define TCP_MODE_T1_SHIFT 4

// Machine cycle: twelve oscillator clocks, phases counted from zero.
`define TCP_CYCLE_LEN 12
`define TCP_PHASE_SAMPLE 4'h9
`define TCP_PHASE_UPDATE 4'h4

// Reset values.
`define TCP_RST_BYTE 8'h00

`endif

//--- tcp_phase_gen.sv
/*
 * Machine cycle phase generator: divides the oscillator clock by the
 * cycle length and emits one-cycle sample and update enables.
 * Assumes sys_clk is the oscillator clock and a synchronous reset.
 */
`timescale 1ns/1ps
`include "tcp_consts.svh"

module tcp_phase_gen #(
  parameter int CYCLE_LEN = `TCP_CYCLE_LEN
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Phase enables.
  output logic sample_tick,
  output logic update_tick
);

  logic [3:0] phase_ff;
  logic [3:0] nxt_phase;

  always_comb begin
    if (phase_ff == 4'(CYCLE_LEN - 1)) begin
      nxt_phase = 4'h0;
    end else begin
      nxt_phase = phase_ff + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase_ff <= 4'h0;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // Enables line up with the phase count so that both pulses land once
  // per machine cycle.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sample_tick <= 1'b0;
      update_tick <= 1'b0;
    end else begin
      sample_tick <= (nxt_phase == `TCP_PHASE_SAMPLE);
      update_tick <= (nxt_phase == `TCP_PHASE_UPDATE);
    end
  end

endmodule // tcp_phase_gen

//--- tcp_pin_model.sv
/* Model of the external count and interrupt pins.
   Assumes the testbench calls its tasks; pins idle high on pull-ups. */
`timescale 1ns/1ps

module tcp_pin_model #(
  parameter int HOLD = 16
) (
  // Clock.
  input wire logic sys_clk,
  // Count and interrupt pins.
  output logic count_pin_0,
  output logic count_pin_1,
  output logic ext_irq0_pin,
  output logic ext_irq1_pin
);
  initial begin
    count_pin_0 = 1'b1;
    count_pin_1 = 1'b1;
    ext_irq0_pin = 1'b1;
    ext_irq1_pin = 1'b1;
  end

  // Each level is held past a machine cycle plus the input filter delay.
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      count_pin_0 <= 1'b0;
      count_pin_1 <= 1'b0;
      repeat (HOLD) @(posedge sys_clk);
      count_pin_0 <= 1'b1;
      count_pin_1 <= 1'b1;
      repeat (HOLD) @(posedge sys_clk);
    end
  endtask

  task automatic set_irq(input int idx, input logic lvl);
    @(posedge sys_clk);
    if (idx == 0) ext_irq0_pin <= lvl;
    else ext_irq1_pin <= lvl;
  endtask
endmodule // tcp_pin_model

//--- tcp_pkg.sv
/*
 * Types shared by the timer/counter pair.
 * Assumes nothing of its surroundings.
 */
package tcp_pkg;

  typedef enum logic [1:0] {
    TCP_MODE_13BIT = 2'b00,
    TCP_MODE_16BIT = 2'b01,
    TCP_MODE_RELOAD = 2'b10,
    TCP_MODE_SPLIT = 2'b11
  } tcp_mode_t;

endpackage

//--- tcp_timer_pair.sv
/*
 * Two 16-bit timer/counters with external interrupt edge/level flags,
 * reached through the processor's special function register port.
 * Assumes sys_clk is the oscillator clock, a synchronous active-low
 * reset, and pins that are asynchronous to sys_clk.
 */
`timescale 1ns/1ps
`include "tcp_consts.svh"

module tcp_timer_pair
  import tcp_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Special function register port.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Interrupt vectoring acknowledges from the processor.
  input wire logic t0_irq_ack,
  input wire logic t1_irq_ack,
  input wire logic xint0_irq_ack,
  input wire logic xint1_irq_ack,
  // External pins.
  input wire logic count_pin_0,
  input wire logic count_pin_1,
  input wire logic ext_irq0_pin,
  input wire logic ext_irq1_pin,
  // Interrupt request flags.
  output logic t0_overflow_flag,
  output logic t1_overflow_flag,
  output logic xint0_edge_flag,
  output logic xint1_edge_flag
);

  // ********************************************************************
  // Declarations
  // ********************************************************************
  logic sample_tick;
  logic update_tick;
  logic [3:0] pin_raw;
  logic [3:0] pin_filt;
  logic [3:0] pin_prev_ff;
  logic [1:0] cnt_samp_ff;
  logic [1:0] cnt_pend_ff;
  logic t0_run_bit_ff;
  logic t1_run_bit_ff;
  logic xint0_type_bit_ff;
  logic xint1_type_bit_ff;
  logic [7:0] timer_mode_ff;
  logic [7:0] t0_low_byte_ff;
  logic [7:0] t0_high_byte_ff;
  logic [7:0] t1_low_byte_ff;
  logic [7:0] t1_high_byte_ff;
  logic [7:0] nxt_t0_low;
  logic [7:0] nxt_t0_high;
  logic [7:0] nxt_t1_low;
  logic [7:0] nxt_t1_high;
  logic [16:0] step0;
  logic [16:0] step1;
  tcp_mode_t mode0;
  tcp_mode_t mode1;
  logic en0;
  logic en1;
  logic inc0;
  logic inc1;
  logic inc0_split_hi;
  logic ovf0;
  logic ovf1;
  logic wr_ctl;
  logic irq0_fall;
  logic irq1_fall;
  logic [7:0] ctl_view;
  logic [7:0] nxt_rdata;

  // ********************************************************************
  // Machine cycle phases
  // ********************************************************************
  tcp_phase_gen #(
    .CYCLE_LEN(`TCP_CYCLE_LEN)
  ) i_tcp_phase_gen (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .sample_tick(sample_tick),
    .update_tick(update_tick)
  );

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  assign pin_raw = {ext_irq1_pin, ext_irq0_pin, count_pin_1, count_pin_0};

  // Three synchroniser flops and a filter flop per pin; a new level is taken only once the second and
  // third stages agree, which rejects a level caught mid-transition.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic filt_ff;
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          s1_ff <= 1'b1;
          s2_ff <= 1'b1;
          s3_ff <= 1'b1;
          filt_ff <= 1'b1;
        end else begin
          s1_ff <= pin_raw[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          if (s2_ff == s3_ff) begin
            filt_ff <= s3_ff;
          end
        end
      end
      assign pin_filt[gi] = filt_ff;
    end
  endgenerate

  // ********************************************************************
  // Count pin sampling
  // ********************************************************************
  // One sample per machine cycle; a high sample followed by a low one
  // leaves a pending event for the next update phase, so one falling
  // edge needs two machine cycles and the rate tops out at 1/24.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_samp_ff <= 2'b11;
      cnt_pend_ff <= 2'b00;
    end else begin
      if (sample_tick) begin
        cnt_samp_ff <= pin_filt[1:0];
      end
      for (int i = 0; i < 2; i++) begin
        if (sample_tick && cnt_samp_ff[i] && !pin_filt[i]) begin
          cnt_pend_ff[i] <= 1'b1;
        end else if (update_tick) begin
          cnt_pend_ff[i] <= 1'b0;
        end
      end
    end
  end

  // ********************************************************************
  // Count enables
  // ********************************************************************
  assign mode0 = tcp_mode_t'(timer_mode_ff[`TCP_MODE_SEL_HI:
                                           `TCP_MODE_SEL_LO]);
  assign mode1 = tcp_mode_t'(timer_mode_ff[`TCP_MODE_T1_SHIFT +
                                           `TCP_MODE_SEL_HI:
                                           `TCP_MODE_T1_SHIFT +
                                           `TCP_MODE_SEL_LO]);

  assign en0 = t0_run_bit_ff &&
               (!timer_mode_ff[`TCP_MODE_GATE] || pin_filt[2]);
  assign en1 = t1_run_bit_ff &&
               (!timer_mode_ff[`TCP_MODE_T1_SHIFT + `TCP_MODE_GATE] ||
                pin_filt[3]);

  // Timer function counts every update phase; counter function only when
  // an edge is pending.
  assign inc0 = update_tick && en0 &&
                (!timer_mode_ff[`TCP_MODE_CNT] ||
                 cnt_pend_ff[0]);
  assign inc1 = update_tick && en1 && (mode1 != TCP_MODE_SPLIT) &&
                (!timer_mode_ff[`TCP_MODE_T1_SHIFT + `TCP_MODE_CNT] ||
                 cnt_pend_ff[1]);

  // The split high byte is a pure machine cycle timer on timer 1's run bit.
  assign inc0_split_hi = update_tick && (mode0 == TCP_MODE_SPLIT) &&
                         t1_run_bit_ff;

  // ********************************************************************
  // Count step
  // ********************************************************************
  // Returns {overflow, high, low} after one count in the given mode.
  function automatic logic [16:0] tcp_step(input tcp_mode_t m,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [5:0] pre;
    logic [16:0] res;
    begin
      pre = {1'b0, lo[4:0]} + 6'h01;
      res = {1'b0, hi, lo};
      case (m)
        TCP_MODE_13BIT: begin
          // Upper three low-byte bits are left as they stand.
          if (pre[5]) begin
            res = {(hi == 8'hFF), hi + 8'h01, lo[7:5], pre[4:0]};
          end else begin
            res = {1'b0, hi, lo[7:5], pre[4:0]};
          end
        end
        TCP_MODE_16BIT: begin
          res = {1'b0, hi, lo} + 17'h0_0001;
        end
        TCP_MODE_RELOAD: begin
          if (lo == 8'hFF) begin
            res = {1'b1, hi, hi};
          end else begin
            res = {1'b0, hi, lo + 8'h01};
          end
        end
        TCP_MODE_SPLIT: begin
          res = {(lo == 8'hFF), hi, lo + 8'h01};
        end
        default: begin
          res = {1'b0, hi, lo};
        end
      endcase
      tcp_step = res;
    end
  endfunction

  assign step0 = tcp_step(mode0, t0_low_byte_ff, t0_high_byte_ff);
  assign step1 = tcp_step(mode1, t1_low_byte_ff, t1_high_byte_ff);

  // ********************************************************************
  // Count registers
  // ********************************************************************
  // A software write in the same cycle as a count wins, so software sees
  // exactly the value it wrote.
  always_comb begin
    nxt_t0_low = t0_low_byte_ff;
    nxt_t0_high = t0_high_byte_ff;
    nxt_t1_low = t1_low_byte_ff;
    nxt_t1_high = t1_high_byte_ff;
    if (inc0) begin
      nxt_t0_low = step0[7:0];
      nxt_t0_high = step0[15:8];
    end
    if (inc0_split_hi) begin
      nxt_t0_high = t0_high_byte_ff + 8'h01;
    end
    if (inc1) begin
      nxt_t1_low = step1[7:0];
      nxt_t1_high = step1[15:8];
    end
    if (sfr_wr && sfr_addr == `TCP_ADDR_T0_LO) begin
      nxt_t0_low = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == `TCP_ADDR_T0_HI) begin
      nxt_t0_high = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == `TCP_ADDR_T1_LO) begin
      nxt_t1_low = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == `TCP_ADDR_T1_HI) begin
      nxt_t1_high = sfr_wdata;
    end
  end

  // Nothing here reacts to the run bits, so starting never clears counts.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      t0_low_byte_ff <= `TCP_RST_BYTE;
      t0_high_byte_ff <= `TCP_RST_BYTE;
      t1_low_byte_ff <= `TCP_RST_BYTE;
      t1_high_byte_ff <= `TCP_RST_BYTE;
    end else begin
      t0_low_byte_ff <= nxt_t0_low;
      t0_high_byte_ff <= nxt_t0_high;
      t1_low_byte_ff <= nxt_t1_low;
      t1_high_byte_ff <= nxt_t1_high;
    end
  end

  // ********************************************************************
  // Mode and control bits
  // ********************************************************************
  assign wr_ctl = sfr_wr && (sfr_addr == `TCP_ADDR_CTL);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      timer_mode_ff <= `TCP_RST_BYTE;
    end else if (sfr_wr && sfr_addr == `TCP_ADDR_MODE) begin
      timer_mode_ff <= sfr_wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      t0_run_bit_ff <= 1'b0;
      t1_run_bit_ff <= 1'b0;
      xint0_type_bit_ff <= 1'b0;
      xint1_type_bit_ff <= 1'b0;
    end else if (wr_ctl) begin
      t0_run_bit_ff <= sfr_wdata[`TCP_BIT_TR0];
      t1_run_bit_ff <= sfr_wdata[`TCP_BIT_TR1];
      xint0_type_bit_ff <= sfr_wdata[`TCP_BIT_IT0];
      xint1_type_bit_ff <= sfr_wdata[`TCP_BIT_IT1];
    end
  end

  // ********************************************************************
  // Overflow flags
  // ********************************************************************
  // While timer 0 is split, timer 1's own overflow no longer reaches its
  // flag; the split high byte owns it.
  assign ovf0 = inc0 && step0[16];
  assign ovf1 = (inc1 && step1[16] && mode0 != TCP_MODE_SPLIT) ||
                (inc0_split_hi && t0_high_byte_ff == 8'hFF);

  // Hardware set beats a software write, which beats the acknowledge.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      t0_overflow_flag <= 1'b0;
      t1_overflow_flag <= 1'b0;
    end else begin
      if (ovf0) begin
        t0_overflow_flag <= 1'b1;
      end else if (wr_ctl) begin
        t0_overflow_flag <= sfr_wdata[`TCP_BIT_TF0];
      end else if (t0_irq_ack) begin
        t0_overflow_flag <= 1'b0;
      end
      if (ovf1) begin
        t1_overflow_flag <= 1'b1;
      end else if (wr_ctl) begin
        t1_overflow_flag <= sfr_wdata[`TCP_BIT_TF1];
      end else if (t1_irq_ack) begin
        t1_overflow_flag <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // External interrupt flags
  // ********************************************************************
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_prev_ff <= 4'hF;
    end else begin
      pin_prev_ff <= pin_filt;
    end
  end

  assign irq0_fall = pin_prev_ff[2] && !pin_filt[2];
  assign irq1_fall = pin_prev_ff[3] && !pin_filt[3];

  // Level mode mirrors the inverted pin, so the request drops by itself
  // once the source releases it; the acknowledge only matters for edges.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      xint0_edge_flag <= 1'b0;
      xint1_edge_flag <= 1'b0;
    end else begin
      if (!xint0_type_bit_ff) begin
        xint0_edge_flag <= !pin_filt[2];
      end else if (irq0_fall) begin
        xint0_edge_flag <= 1'b1;
      end else if (wr_ctl) begin
        xint0_edge_flag <= sfr_wdata[`TCP_BIT_IE0];
      end else if (xint0_irq_ack) begin
        xint0_edge_flag <= 1'b0;
      end
      if (!xint1_type_bit_ff) begin
        xint1_edge_flag <= !pin_filt[3];
      end else if (irq1_fall) begin
        xint1_edge_flag <= 1'b1;
      end else if (wr_ctl) begin
        xint1_edge_flag <= sfr_wdata[`TCP_BIT_IE1];
      end else if (xint1_irq_ack) begin
        xint1_edge_flag <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Register read
  // ********************************************************************
  assign ctl_view = {t1_overflow_flag, t1_run_bit_ff, t0_overflow_flag,
                     t0_run_bit_ff, xint1_edge_flag, xint1_type_bit_ff,
                     xint0_edge_flag, xint0_type_bit_ff};

  always_comb begin
    case (sfr_addr)
      `TCP_ADDR_CTL: nxt_rdata = ctl_view;
      `TCP_ADDR_MODE: nxt_rdata = timer_mode_ff;
      `TCP_ADDR_T0_LO: nxt_rdata = t0_low_byte_ff;
      `TCP_ADDR_T0_HI: nxt_rdata = t0_high_byte_ff;
      `TCP_ADDR_T1_LO: nxt_rdata = t1_low_byte_ff;
      `TCP_ADDR_T1_HI: nxt_rdata = t1_high_byte_ff;
      default: nxt_rdata = `TCP_UNMAPPED_READ;
    endcase
  end

  // Read data is held until the next read so the output stays registered.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      sfr_rdata <= `TCP_RST_BYTE;
    end else if (sfr_rd) begin
      sfr_rdata <= nxt_rdata;
    end
  end

endmodule // tcp_timer_pair

//--- tcp_timer_pair_props.sv
/* Port-level checker for the timer/counter pair.
   Assumes binding to tcp_timer_pair and the map in tcp_consts.svh. */
`timescale 1ns/1ps
`include "tcp_consts.svh"

module tcp_timer_pair_props (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port.
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_rdata,
  // Acknowledges, pins and flags.
  input wire logic t0_irq_ack,
  input wire logic t1_irq_ack,
  input wire logic ext_irq0_pin,
  input wire logic t0_overflow_flag,
  input wire logic t1_overflow_flag,
  input wire logic xint0_edge_flag,
  input wire logic xint1_edge_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic mapped;
  assign mapped = sfr_addr >= `TCP_ADDR_CTL && sfr_addr <= `TCP_ADDR_T1_HI;

  /********************/
  /* Port relations   */
  /********************/
  a_rdata_holds: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctl_readback: assert property (
    sfr_wr && sfr_addr == `TCP_ADDR_CTL ##1 !sfr_wr
    ##1 sfr_rd && sfr_addr == `TCP_ADDR_CTL
    |=> (sfr_rdata & 8'h55) == ($past(sfr_wdata, 3) & 8'h55))
    else $error("control run or type bits lost");
  a_mode_readback: assert property (
    sfr_wr && sfr_addr == `TCP_ADDR_MODE ##1 !sfr_wr
    ##1 sfr_rd && sfr_addr == `TCP_ADDR_MODE
    |=> sfr_rdata == $past(sfr_wdata, 3))
    else $error("mode register lost");
  a_t0_ack_clears: assert property (
    t0_irq_ack && !sfr_wr |=> !t0_overflow_flag)
    else $error("t0 flag survived acknowledge");
  a_t1_ack_clears: assert property (
    t1_irq_ack && !sfr_wr |=> !t1_overflow_flag)
    else $error("t1 flag survived acknowledge");
  a_sw_sets_flags: assert property (
    sfr_wr && sfr_addr == `TCP_ADDR_CTL && sfr_wdata[7] && sfr_wdata[5]
    |=> t1_overflow_flag && t0_overflow_flag)
    else $error("written flags not set");
  a_quiet_pin: assert property (
    ext_irq0_pin [*8] |-> !$rose(xint0_edge_flag) || $past(sfr_wr))
    else $error("interrupt flag rose with pin high");
  a_reset_clears: assert property (disable iff (1'b0)
    !reset_n |=> !t0_overflow_flag && !t1_overflow_flag
    && !xint0_edge_flag && !xint1_edge_flag && sfr_rdata == 8'h00)
    else $error("outputs not cleared by reset");

  c_t0_ovf: cover property ($rose(t0_overflow_flag));
  c_xint0: cover property ($rose(xint0_edge_flag));
  c_unmapped: cover property (sfr_rd && !mapped);
endmodule // tcp_timer_pair_props

bind tcp_timer_pair tcp_timer_pair_props i_tcp_timer_pair_props (
  .sys_clk, .reset_n, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd,
  .sfr_rdata, .t0_irq_ack, .t1_irq_ack, .ext_irq0_pin,
  .t0_overflow_flag, .t1_overflow_flag, .xint0_edge_flag,
  .xint1_edge_flag);
